// File: verilog/ser_regs.svh
`ifndef SER_REGS_SVH
`define SER_REGS_SVH

// standard event status field positions
`define SER_BIT_POWER_ON 7
`define SER_BIT_USER_REQ 6
`define SER_BIT_CMD_ERR 5
`define SER_BIT_EXEC_ERR 4
`define SER_BIT_DEV_ERR 3
`define SER_BIT_QUERY_ERR 2
`define SER_BIT_REQ_CTL 1
`define SER_BIT_OP_DONE 0

// status summary byte field positions
`define SER_SB_SVC 6
`define SER_SB_EVT_SUM 5
`define SER_SB_MSG 4
`define SER_SB_UNUSED 8'h8f

// bits that hardware may ever set or hold
`define SER_EVT_IMPL 8'hbd
`define SER_SRV_IMPL 8'h30

// enable values loaded with power-on clear
`define SER_DEV_EN_PSC 8'hff
`define SER_SUM_EN_PSC 8'h00
`define SER_SRV_EN_PSC 8'h00

`define SER_ZERO8 8'h00

`endif

// File: verilog/ser_pkg.sv
package ser_pkg;

	typedef enum logic [0:0] {
		st_init = 1'h0,
		st_run = 1'h1
	} ser_state_t;

	typedef struct packed {
		ser_state_t st;
		logic [7:0] evt_stat;
		logic [7:0] dev_en;
		logic [7:0] sum_en;
		logic [7:0] srv_en;
		logic req_svc;
		logic master_prev;
		logic op_armed;
		logic [7:0] rd_data;
		logic rd_valid;
		logic [7:0] eq_evt;
		logic eq_push;
	} ser_st_t;

endpackage

// File: verilog/ser_top.sv
`timescale 1ns/100ps
`include "ser_regs.svh"

module ser_top (
	input wire logic sys_clk, // system clock
	input wire logic rstn, // async reset, low
	input wire logic evt_power_on, // power-on event pulse
	input wire logic evt_cmd_err, // parse error pulse
	input wire logic evt_exec_err, // execution error pulse
	input wire logic evt_dev_err, // device error pulse
	input wire logic evt_query_err, // query error pulse
	input wire logic op_cmpl_cmd, // completion command pulse
	input wire logic ops_busy, // operations pending level
	input wire logic oq_has_data, // output queue not empty
	input wire logic psc_clear, // power-on clear select
	input wire logic [7:0] nv_dev_en, // stored device mask
	input wire logic [7:0] nv_sum_en, // stored summary mask
	input wire logic [7:0] nv_srv_en, // stored service mask
	input wire logic [7:0] cmd_wdata, // write data
	input wire logic cmd_dev_en_wr, // write device mask
	input wire logic cmd_sum_en_wr, // write summary mask
	input wire logic cmd_srv_en_wr, // write service mask
	input wire logic qry_dev_en, // read device mask
	input wire logic qry_sum_en, // read summary mask
	input wire logic qry_srv_en, // read service mask
	input wire logic qry_evt_stat, // read and clear events
	input wire logic qry_stb, // status byte query
	input wire logic serial_poll, // serial poll read
	output logic [7:0] rd_data, // query answer
	output logic rd_valid, // answer strobe
	output logic srv_request, // service request to bus
	output logic eq_push, // event queue entry strobe
	output logic [7:0] eq_evt, // events entered
	output logic [7:0] dev_en_out, // device mask for saving
	output logic [7:0] sum_en_out, // summary mask for saving
	output logic [7:0] srv_en_out // service mask for saving
);
	import ser_pkg::*;

	ser_st_t s;
	ser_st_t n;

	logic [7:0] raw_evt;
	logic [7:0] gate_en;
	logic [7:0] set_evt;
	logic op_done;
	logic evt_sum;
	logic msg_avail;
	logic master_sum;
	logic [7:0] sb_base;
	logic [7:0] sb_query;
	logic [7:0] sb_poll;
	logic [7:0] init_dev;

	// the device mask that applies in the load cycle comes straight from the load value,
	// so the power-on event is judged against what software sees afterwards
	assign init_dev = psc_clear ? `SER_DEV_EN_PSC : nv_dev_en;
	assign gate_en = (s.st == st_init) ? init_dev : s.dev_en;

	assign op_done = s.op_armed & ~ops_busy;

	always_comb begin
		raw_evt = `SER_ZERO8;
		raw_evt[`SER_BIT_POWER_ON] = evt_power_on | (s.st == st_init);
		raw_evt[`SER_BIT_CMD_ERR] = evt_cmd_err;
		raw_evt[`SER_BIT_EXEC_ERR] = evt_exec_err;
		raw_evt[`SER_BIT_DEV_ERR] = evt_dev_err;
		raw_evt[`SER_BIT_QUERY_ERR] = evt_query_err;
		raw_evt[`SER_BIT_OP_DONE] = op_done;
	end

	// the implemented mask keeps bits 6 and 1 dead whatever the enable says
	assign set_evt = raw_evt & gate_en & `SER_EVT_IMPL;

	assign evt_sum = |(s.evt_stat & s.sum_en);
	assign msg_avail = oq_has_data;
	assign master_sum = (evt_sum & s.srv_en[`SER_SB_EVT_SUM])
		| (msg_avail & s.srv_en[`SER_SB_MSG]);

	always_comb begin
		sb_base = `SER_ZERO8;
		sb_base[`SER_SB_EVT_SUM] = evt_sum;
		sb_base[`SER_SB_MSG] = msg_avail;
		sb_query = sb_base;
		sb_query[`SER_SB_SVC] = master_sum;
		sb_poll = sb_base;
		sb_poll[`SER_SB_SVC] = s.req_svc;
	end

	always_comb begin
		n = s;
		n.rd_valid = 1'b0;
		n.eq_push = 1'b0;
		n.eq_evt = `SER_ZERO8;
		n.master_prev = master_sum;
		// a poll in the same cycle as a new rise still leaves the request up
		n.req_svc = (master_sum & ~s.master_prev)
			| (s.req_svc & master_sum & ~serial_poll);
		unique case (s.st)
			st_init: begin
				n.dev_en = init_dev;
				n.sum_en = psc_clear ? `SER_SUM_EN_PSC : nv_sum_en;
				n.srv_en = (psc_clear ? `SER_SRV_EN_PSC : nv_srv_en)
					& `SER_SRV_IMPL;
				n.evt_stat = set_evt;
				n.eq_push = |set_evt;
				n.eq_evt = set_evt;
				n.req_svc = 1'b0;
				n.st = st_run;
			end
			st_run: begin
				// a read clears, but an event in the same cycle survives it
				if (qry_evt_stat) begin
					n.evt_stat = set_evt;
				end else begin
					n.evt_stat = s.evt_stat | set_evt;
				end
				n.eq_push = |set_evt;
				n.eq_evt = set_evt;
				if (op_done) begin
					n.op_armed = 1'b0;
				end
				if (op_cmpl_cmd) begin
					n.op_armed = 1'b1;
				end
				if (cmd_dev_en_wr) begin
					n.dev_en = cmd_wdata;
				end
				if (cmd_sum_en_wr) begin
					n.sum_en = cmd_wdata;
				end
				if (cmd_srv_en_wr) begin
					n.srv_en = cmd_wdata & `SER_SRV_IMPL;
				end
				// one answer per cycle; simultaneous reads are served by priority
				n.rd_valid = qry_evt_stat | qry_stb | serial_poll
					| qry_dev_en | qry_sum_en | qry_srv_en;
				if (qry_evt_stat) begin
					n.rd_data = s.evt_stat;
				end else if (qry_stb) begin
					n.rd_data = sb_query;
				end else if (serial_poll) begin
					n.rd_data = sb_poll;
				end else if (qry_dev_en) begin
					n.rd_data = s.dev_en;
				end else if (qry_sum_en) begin
					n.rd_data = s.sum_en;
				end else if (qry_srv_en) begin
					n.rd_data = s.srv_en;
				end
			end
		endcase
	end

	// registers are at most eight bits each; no wider state is kept
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s.st <= st_init;
			s.evt_stat <= `SER_ZERO8;
			s.dev_en <= `SER_ZERO8;
			s.sum_en <= `SER_ZERO8;
			s.srv_en <= `SER_ZERO8;
			s.req_svc <= 1'b0;
			s.master_prev <= 1'b0;
			s.op_armed <= 1'b0;
			s.rd_data <= `SER_ZERO8;
			s.rd_valid <= 1'b0;
			s.eq_evt <= `SER_ZERO8;
			s.eq_push <= 1'b0;
		end else begin
			s <= n;
		end
	end

	assign rd_data = s.rd_data;
	assign rd_valid = s.rd_valid;
	assign srv_request = s.req_svc;
	assign eq_push = s.eq_push;
	assign eq_evt = s.eq_evt;
	assign dev_en_out = s.dev_en;
	assign sum_en_out = s.sum_en;
	assign srv_en_out = s.srv_en;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	a_user_req_zero: assert property (
		!s.evt_stat[`SER_BIT_USER_REQ]
	) else $error("user request bit set");

	a_req_ctl_zero: assert property (
		!s.evt_stat[`SER_BIT_REQ_CTL]
	) else $error("request control bit set");

	a_cmd_err_set: assert property (
		(s.st == st_run && evt_cmd_err && s.dev_en[`SER_BIT_CMD_ERR])
		|=> s.evt_stat[`SER_BIT_CMD_ERR]
	) else $error("command error not recorded");

	a_masked_hold: assert property (
		(s.st == st_run && !s.dev_en[`SER_BIT_EXEC_ERR] && !qry_evt_stat)
		|=> s.evt_stat[`SER_BIT_EXEC_ERR] == $past(s.evt_stat[`SER_BIT_EXEC_ERR])
	) else $error("masked event changed status");

	a_esr_read_clr: assert property (
		(s.st == st_run && qry_evt_stat && set_evt == `SER_ZERO8)
		|=> rd_valid && rd_data == $past(s.evt_stat) && s.evt_stat == `SER_ZERO8
	) else $error("event status read did not clear");

	a_stb_stable: assert property (
		(s.st == st_run && (qry_stb || serial_poll) && !qry_evt_stat
			&& set_evt == `SER_ZERO8)
		|=> $stable(s.evt_stat)
			&& (s.req_svc || !($past(s.req_svc) && $past(master_sum) && !$past(serial_poll)))
	) else $error("summary read changed state");

	a_stb_bit6: assert property (
		(s.st == st_run && qry_stb && !qry_evt_stat)
		|=> rd_valid && rd_data[`SER_SB_SVC] == $past(master_sum)
	) else $error("query bit 6 is not master summary");

	a_poll_bit6: assert property (
		(s.st == st_run && serial_poll && !qry_evt_stat && !qry_stb)
		|=> rd_data[`SER_SB_SVC] == $past(s.req_svc)
	) else $error("poll bit 6 is not request latch");

	a_sb_unused: assert property (
		(s.st == st_run && (qry_stb || serial_poll) && !qry_evt_stat)
		|=> (rd_data & `SER_SB_UNUSED) == `SER_ZERO8
	) else $error("unused summary bit set");

	a_req_rise: assert property (
		(master_sum && !s.master_prev && s.st == st_run) |=> srv_request
	) else $error("no service request on rise");

	a_req_drop: assert property (
		(!master_sum) |=> !srv_request
	) else $error("request held without summary");

	a_req_hold: assert property (
		(srv_request && master_sum && !serial_poll) |=> srv_request
	) else $error("request dropped early");

	a_psc_load: assert property (
		(s.st == st_init && psc_clear)
		|=> s.dev_en == `SER_DEV_EN_PSC && s.sum_en == `SER_SUM_EN_PSC
			&& s.srv_en == `SER_SRV_EN_PSC
	) else $error("power-on clear values wrong");

	a_op_done: assert property (
		(s.st == st_run && op_cmpl_cmd) ##1 (!ops_busy && s.dev_en[`SER_BIT_OP_DONE])
		|=> s.evt_stat[`SER_BIT_OP_DONE]
	) else $error("completion not recorded");

	a_power_on_set: assert property (
		(s.st == st_run && evt_power_on && s.dev_en[`SER_BIT_POWER_ON])
		|=> s.evt_stat[`SER_BIT_POWER_ON]
	) else $error("power on event not recorded");

	a_exec_err_set: assert property (
		(s.st == st_run && evt_exec_err && s.dev_en[`SER_BIT_EXEC_ERR])
		|=> s.evt_stat[`SER_BIT_EXEC_ERR]
	) else $error("execution error not recorded");

	a_dev_err_set: assert property (
		(s.st == st_run && evt_dev_err && s.dev_en[`SER_BIT_DEV_ERR])
		|=> s.evt_stat[`SER_BIT_DEV_ERR]
	) else $error("device error not recorded");

	a_query_err_set: assert property (
		(s.st == st_run && evt_query_err && s.dev_en[`SER_BIT_QUERY_ERR])
		|=> s.evt_stat[`SER_BIT_QUERY_ERR]
	) else $error("query error not recorded");

	a_evt_sum_bit: assert property (
		(s.st == st_run && qry_stb && !qry_evt_stat)
		|=> rd_data[`SER_SB_EVT_SUM] == (|($past(s.evt_stat) & $past(s.sum_en)))
	) else $error("event summary bit wrong");

	a_msg_avail_bit: assert property (
		(s.st == st_run && qry_stb && !qry_evt_stat)
		|=> rd_data[`SER_SB_MSG] == $past(oq_has_data)
	) else $error("message available bit wrong");

	a_srv_unused: assert property (
		(s.st == st_run)
		|-> (srv_en_out & ~`SER_SRV_IMPL) == `SER_ZERO8
	) else $error("unused service mask bit set");

	a_dev_wr: assert property (
		(s.st == st_run && cmd_dev_en_wr)
		|=> dev_en_out == $past(cmd_wdata)
	) else $error("device mask write lost");

	a_sum_wr: assert property (
		(s.st == st_run && cmd_sum_en_wr)
		|=> sum_en_out == $past(cmd_wdata)
	) else $error("summary mask write lost");

	a_srv_wr: assert property (
		(s.st == st_run && cmd_srv_en_wr)
		|=> srv_en_out == ($past(cmd_wdata) & `SER_SRV_IMPL)
	) else $error("service mask write lost");

	a_eq_masked: assert property (
		(s.st == st_run && !s.dev_en[`SER_BIT_DEV_ERR])
		|=> !eq_evt[`SER_BIT_DEV_ERR]
	) else $error("masked event entered queue");

	a_eq_dead: assert property (
		(s.st == st_run)
		|=> !eq_evt[`SER_BIT_USER_REQ] && !eq_evt[`SER_BIT_REQ_CTL]
	) else $error("unused event entered queue");

	a_query_queued: assert property (
		(s.st == st_run && evt_query_err && s.dev_en[`SER_BIT_QUERY_ERR])
		|=> eq_push && eq_evt[`SER_BIT_QUERY_ERR]
	) else $error("enabled event not queued");

	a_psc_keep: assert property (
		(s.st == st_init && !psc_clear)
		|=> dev_en_out == $past(nv_dev_en) && sum_en_out == $past(nv_sum_en)
			&& srv_en_out == ($past(nv_srv_en) & `SER_SRV_IMPL)
	) else $error("stored masks not kept");

	a_load_power_on: assert property (
		(s.st == st_init && psc_clear)
		|=> s.evt_stat[`SER_BIT_POWER_ON] && eq_push
	) else $error("power on not raised at load");

	a_req_masked: assert property (
		(s.srv_en == `SER_ZERO8)
		|=> !srv_request
	) else $error("request with empty service mask");

	a_poll_clear: assert property (
		(s.st == st_run && srv_request && serial_poll && s.master_prev)
		|=> !srv_request
	) else $error("poll did not clear request");

	a_done_idle: assert property (
		(s.st == st_run && !s.op_armed)
		|=> !eq_evt[`SER_BIT_OP_DONE]
	) else $error("completion without command");

	a_done_busy: assert property (
		(s.st == st_run && ops_busy)
		|=> !eq_evt[`SER_BIT_OP_DONE]
	) else $error("completion while busy");

	a_query_valid: assert property (
		(s.st == st_run && (qry_dev_en || qry_sum_en || qry_srv_en))
		|=> rd_valid
	) else $error("mask query not answered");

	c_esr_read: cover property (qry_evt_stat && s.evt_stat != `SER_ZERO8);
	c_req_rise: cover property ($rose(srv_request));
	c_poll_req: cover property (serial_poll && srv_request);
	c_eq_push: cover property (eq_push && eq_evt[`SER_BIT_CMD_ERR]);
	c_op_done: cover property (eq_push && eq_evt[`SER_BIT_OP_DONE]);

endmodule

// File: tb/ser_ctl_model.sv
`timescale 1ns/100ps
module ser_ctl_model (
	input wire logic sys_clk, // system clock
	input wire logic run, // allow traffic
	output logic [7:0] cmd_wdata, // mask write data
	output logic cmd_dev_en_wr, // device mask write
	output logic cmd_sum_en_wr, // summary mask write
	output logic cmd_srv_en_wr, // service mask write
	output logic qry_dev_en, // device mask query
	output logic qry_sum_en, // summary mask query
	output logic qry_srv_en, // service mask query
	output logic qry_evt_stat, // event status query
	output logic qry_stb, // status byte query
	output logic serial_poll // serial poll
);
	integer seed = 32'hddf3_65cb;
	logic [31:0] r;
	logic [31:0] q;
	// strobes move only on the falling edge so each value is held across exactly one rising edge
	always @(negedge sys_clk) begin
		r = $random(seed);
		q = $random(seed);
		cmd_wdata <= q[7:0];
		cmd_dev_en_wr <= run && r[4:0] == 5'h00;
		cmd_sum_en_wr <= run && r[9:5] == 5'h00;
		cmd_srv_en_wr <= run && r[14:10] == 5'h00;
		qry_dev_en <= run && r[18:15] == 4'h0;
		qry_sum_en <= run && r[22:19] == 4'h0;
		qry_srv_en <= run && r[26:23] == 4'h0;
		qry_evt_stat <= run && r[29:27] == 3'h0;
		qry_stb <= run && q[10:8] == 3'h0;
		serial_poll <= run && q[13:11] == 3'h0;
	end
endmodule

// File: tb/status_event_reporting_tb.sv
`timescale 1ns/100ps
module status_event_reporting_tb;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic run = 1'b0;
	logic evt_power_on = 1'b0, evt_cmd_err = 1'b0, evt_exec_err = 1'b0;
	logic evt_dev_err = 1'b0, evt_query_err = 1'b0, op_cmpl_cmd = 1'b0;
	logic ops_busy = 1'b0, oq_has_data = 1'b0, psc_clear = 1'b1;
	logic [7:0] nv_dev_en = 8'h00, nv_sum_en = 8'h00, nv_srv_en = 8'h00;
	logic [7:0] cmd_wdata, rd_data, eq_evt, dev_en_out, sum_en_out, srv_en_out;
	logic cmd_dev_en_wr, cmd_sum_en_wr, cmd_srv_en_wr, qry_dev_en, qry_sum_en;
	logic qry_srv_en, qry_evt_stat, qry_stb, serial_poll, rd_valid, srv_request, eq_push;
	// reference state
	logic [7:0] st, den, sen, srv, rd, eqe, ev, sb;
	logic req, mp, arm, rdv, eqp, es, ms;
	logic [31:0] r;
	integer seed = 32'hddf3_65cb;
	int fails = 0;
	int samples_checked = 0;

	always #2 sys_clk = ~sys_clk;

	ser_ctl_model u_ctl (.sys_clk, .run, .cmd_wdata, .cmd_dev_en_wr, .cmd_sum_en_wr,
		.cmd_srv_en_wr, .qry_dev_en, .qry_sum_en, .qry_srv_en, .qry_evt_stat, .qry_stb,
		.serial_poll);

	ser_top u_ser_top (.sys_clk, .rstn, .evt_power_on, .evt_cmd_err, .evt_exec_err,
		.evt_dev_err, .evt_query_err, .op_cmpl_cmd, .ops_busy, .oq_has_data, .psc_clear,
		.nv_dev_en, .nv_sum_en, .nv_srv_en, .cmd_wdata, .cmd_dev_en_wr, .cmd_sum_en_wr,
		.cmd_srv_en_wr, .qry_dev_en, .qry_sum_en, .qry_srv_en, .qry_evt_stat, .qry_stb,
		.serial_poll, .rd_data, .rd_valid, .srv_request, .eq_push, .eq_evt, .dev_en_out,
		.sum_en_out, .srv_en_out);

	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic compare();
		check("rd_valid", {7'h00, rd_valid}, {7'h00, rdv});
		if (rdv) check("rd_data", rd_data, rd);
		check("srv_request", {7'h00, srv_request}, {7'h00, req});
		check("eq_push", {7'h00, eq_push}, {7'h00, eqp});
		check("eq_evt", eq_evt, eqe);
		check("dev_en", dev_en_out, den);
		check("sum_en", sum_en_out, sen);
		check("srv_en", srv_en_out, srv);
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// a second call lands in mid-traffic, so reset is also exercised while busy
	task automatic do_reset(input logic psc);
		run = 1'b0;
		rstn = 1'b0;
		{evt_power_on, evt_cmd_err, evt_exec_err, evt_dev_err, evt_query_err} = '0;
		op_cmpl_cmd = 1'b0;
		psc_clear = psc;
		r = $random(seed);
		{nv_dev_en, nv_sum_en, nv_srv_en} = r[23:0];
		repeat (3) @(negedge sys_clk);
		check("reset_out", rd_data | eq_evt | dev_en_out | sum_en_out | srv_en_out
			| {5'h00, rd_valid, srv_request, eq_push}, 8'h00);
		rstn = 1'b1;
		@(negedge sys_clk);
		den = psc ? 8'hff : nv_dev_en;
		sen = psc ? 8'h00 : nv_sum_en;
		srv = psc ? 8'h00 : nv_srv_en & 8'h30;
		st = den & 8'h80;
		{eqe, eqp, req, mp, arm, rdv, rd} = {st, st != 8'h00, 4'h0, 8'h00};
		compare();
		run = 1'b1;
	endtask

	task automatic step();
		r = $random(seed);
		evt_power_on = r[3:0] == 4'h0;
		evt_cmd_err = r[6:4] == 3'h0;
		evt_exec_err = r[9:7] == 3'h0;
		evt_dev_err = r[12:10] == 3'h0;
		evt_query_err = r[15:13] == 3'h0;
		op_cmpl_cmd = r[19:16] == 4'h0;
		ops_busy = r[21:20] != 2'h0;
		if (r[26:22] == 5'h00) oq_has_data = ~oq_has_data;
		#1;
		es = |(st & sen);
		ms = (es & srv[5]) | (oq_has_data & srv[4]);
		ev = {evt_power_on, 1'b0, evt_cmd_err, evt_exec_err, evt_dev_err, evt_query_err,
			1'b0, arm & ~ops_busy} & den;
		sb = {1'b0, 1'b0, es, oq_has_data, 4'h0};
		rdv = 1'b1;
		if (qry_evt_stat) rd = st;
		else if (qry_stb) rd = sb | {1'b0, ms, 6'h00};
		else if (serial_poll) rd = sb | {1'b0, req, 6'h00};
		else if (qry_dev_en) rd = den;
		else if (qry_sum_en) rd = sen;
		else if (qry_srv_en) rd = srv;
		else rdv = 1'b0;
		st = qry_evt_stat ? ev : (st | ev);
		{eqp, eqe} = {ev != 8'h00, ev};
		req = (ms & ~mp) | (req & ms & ~serial_poll);
		mp = ms;
		arm = op_cmpl_cmd | (arm & ops_busy);
		if (cmd_dev_en_wr) den = cmd_wdata;
		if (cmd_sum_en_wr) sen = cmd_wdata;
		if (cmd_srv_en_wr) srv = cmd_wdata & 8'h30;
		@(negedge sys_clk);
		compare();
	endtask

	initial begin
		@(negedge sys_clk);
		do_reset(1'b1);
		repeat (6000) step();
		$display("test power_on_clear_traffic done");
		do_reset(1'b0);
		repeat (6000) step();
		$display("test stored_mask_traffic done");
		do_reset(1'b0);
		repeat (3000) step();
		$display("test second_reset_traffic done");
		stop_test();
	end
endmodule
